// File: tpcp_top.sv
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tpcp_top #(
	parameter bit HAS_EXT = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic external_timer_clock,
	output logic chan0_pin,
	output logic chan0_pin_oe,
	output logic chan1_pin,
	output logic chan1_pin_oe,
	output logic irq_overflow,
	output logic irq_chan0,
	output logic irq_chan1,
	output logic wake_request
);
	import tpcp_pkg::*;

	// ======================================================
	// Registers
	logic ovf_flag_q, ovf_ie_q, halt_q, inhib_q, ovf_arm_q;
	logic [2:0] ps_q;
	tpcp_cnt_t cnt_q, mod_q;
	logic [7:0] ctl0_q, ctl1_q;
	tpcp_cnt_t cmp0_q, cmp1_q;
	logic ch0_flag_q, ch1_flag_q, ch0_arm_q, ch1_arm_q;
	logic act_q, pend_q;
	logic bvalid_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// Flag with set priority over clear
	function automatic logic flag_next(input logic f, input logic set, input logic clr);
		flag_next = set || (f && !clr);
	endfunction : flag_next

	// Address decode shared by read and write paths
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= ADDR_CH1_CMP);
	endfunction : mapped

	// ======================================================
	// Bus handshakes: write address and data taken together
	wire wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_wready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	wire rd_fire = s_axi_arvalid && !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// Registers are blocked to software while in wait mode
	wire wr_ok = wr_fire && !wait_mode && mapped(s_axi_awaddr);
	wire rd_ok = rd_fire && !wait_mode && mapped(s_axi_araddr);
	wire b0 = s_axi_wstrb[0];
	wire b1 = s_axi_wstrb[1];
	wire [7:0] wd = s_axi_wdata[7:0];
	wire w_stat = wr_ok && b0 && (s_axi_awaddr == ADDR_STATUS);
	wire w_mhi = wr_ok && b0 && (s_axi_awaddr == ADDR_MOD_HI);
	wire w_mlo = wr_ok && b0 && (s_axi_awaddr == ADDR_MOD_LO);
	wire w_ctl0 = wr_ok && b0 && (s_axi_awaddr == ADDR_CH0_CTRL);
	wire w_ctl1 = wr_ok && b0 && (s_axi_awaddr == ADDR_CH1_CTRL);
	wire w_cmp0 = wr_ok && (b0 || b1) && (s_axi_awaddr == ADDR_CH0_CMP);
	wire w_cmp1 = wr_ok && (b0 || b1) && (s_axi_awaddr == ADDR_CH1_CMP);
	wire r_stat = rd_ok && (s_axi_araddr == ADDR_STATUS);
	wire r_ctl0 = rd_ok && (s_axi_araddr == ADDR_CH0_CTRL);
	wire r_ctl1 = rd_ok && (s_axi_araddr == ADDR_CH1_CTRL);
	wire crst = w_stat && wd[B_CRST];

	// Byte-lane merge for compare words
	function automatic tpcp_cnt_t lane16(input tpcp_cnt_t old, input logic [31:0] d,
		input logic [3:0] s);
		lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : lane16

	// ======================================================
	// Counter and prescaler
	tpcp_cnt_if cif ();
	logic ps_tick;
	// Stop mode freezes the timer without touching any state
	wire run = ps_tick && !halt_q && !stop_mode;
	wire at_mod = (cnt_q == mod_q);
	assign cif.tick = run;
	assign cif.wrap = run && at_mod;
	assign cif.cnt_nxt = at_mod ? 16'h0000 : 16'(cnt_q + 16'h0001);
	wire ovf_evt = run && at_mod && !inhib_q;

	tpcp_prescale #(
		.HAS_EXT(HAS_EXT)
	) u_ps (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(crst),
		.sel(ps_q),
		.ext_clk(external_timer_clock),
		.tick(ps_tick)
	);

	// Counter restart on the software reset bit, else step
	always_ff @(posedge aclk) begin
		if (!aresetn || crst) begin
			cnt_q <= 16'h0000;
		end else if (run) begin
			cnt_q <= cif.cnt_nxt;
		end
	end

	// ======================================================
	// Status and control register
	wire ovf_clr = w_stat && !wd[B_FLAG] && ovf_arm_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovf_flag_q <= 1'b0;
			ovf_arm_q <= 1'b0;
			ovf_ie_q <= 1'b0;
			halt_q <= 1'b1;
			ps_q <= 3'h0;
		end else begin
			ovf_flag_q <= flag_next(ovf_flag_q, ovf_evt, ovf_clr);
			// A fresh overflow voids a half-done clear
			if (ovf_evt || ovf_clr) begin
				ovf_arm_q <= 1'b0;
			end else if (r_stat && ovf_flag_q) begin
				ovf_arm_q <= 1'b1;
			end
			if (w_stat) begin
				ovf_ie_q <= wd[B_IE];
				halt_q <= wd[B_HALT];
				ps_q <= wd[2:0];
			end
		end
	end

	// ======================================================
	// Modulo: high byte write holds off the flag until low byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mod_q <= MOD_RESET;
			inhib_q <= 1'b0;
		end else begin
			if (w_mhi) begin
				mod_q[15:8] <= wd;
			end
			if (w_mlo) begin
				mod_q[7:0] <= wd;
			end
			if (w_mlo) begin
				inhib_q <= 1'b0;
			end else if (w_mhi) begin
				inhib_q <= 1'b1;
			end
		end
	end

	// ======================================================
	// Channel control and compare values
	wire link = ctl0_q[B_LINK];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl0_q <= 8'h00;
			ctl1_q <= 8'h00;
			cmp0_q <= 16'h0000;
			cmp1_q <= 16'h0000;
		end else begin
			if (w_ctl0) begin
				ctl0_q <= wd;
			end
			if (w_ctl1) begin
				ctl1_q <= wd;
			end
			// Written values are live at once when unbuffered
			if (w_cmp0) begin
				cmp0_q <= lane16(cmp0_q, s_axi_wdata, s_axi_wstrb);
			end
			if (w_cmp1) begin
				cmp1_q <= lane16(cmp1_q, s_axi_wdata, s_axi_wstrb);
			end
		end
	end

	// Pair select: last written pair takes over at the next wrap
	always_ff @(posedge aclk) begin
		if (!aresetn || !link) begin
			act_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			if (w_cmp1) begin
				pend_q <= 1'b1;
			end else if (w_cmp0) begin
				pend_q <= 1'b0;
			end
			if (cif.wrap) begin
				act_q <= w_cmp1 ? 1'b1 : (w_cmp0 ? 1'b0 : pend_q);
			end
		end
	end

	// ======================================================
	// Channel units
	wire [15:0] cmp0_use = (link && act_q) ? cmp1_q : cmp0_q;
	logic hit0, hit1;
	tpcp_chan u_ch0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.cnt(cif.snk),
		.cmp(cmp0_use),
		.els(ctl0_q[B_ELSH:B_ELSL]),
		.tov(ctl0_q[B_TOV]),
		.max_duty(ctl0_q[B_MAX]),
		.hit(hit0),
		.pin(chan0_pin)
	);
	tpcp_chan u_ch1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.cnt(cif.snk),
		.cmp(cmp1_q),
		.els(ctl1_q[B_ELSH:B_ELSL]),
		.tov(ctl1_q[B_TOV]),
		.max_duty(ctl1_q[B_MAX]),
		.hit(hit1),
		.pin(chan1_pin)
	);

	// Pins are driven only when an edge action is selected
	assign chan0_pin_oe = ctl0_q[B_ELSH] || ctl0_q[B_ELSL];
	assign chan1_pin_oe = !link && (ctl1_q[B_ELSH] || ctl1_q[B_ELSL]);

	// ======================================================
	// Channel flags, two-step clear like the overflow flag
	wire ch0_evt = hit0 && chan0_pin_oe;
	wire ch1_evt = hit1 && chan1_pin_oe;
	wire ch0_clr = w_ctl0 && !wd[B_FLAG] && ch0_arm_q;
	wire ch1_clr = w_ctl1 && !wd[B_FLAG] && ch1_arm_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch0_flag_q <= 1'b0;
			ch1_flag_q <= 1'b0;
			ch0_arm_q <= 1'b0;
			ch1_arm_q <= 1'b0;
		end else begin
			ch0_flag_q <= flag_next(ch0_flag_q, ch0_evt, ch0_clr);
			ch1_flag_q <= flag_next(ch1_flag_q, ch1_evt, ch1_clr);
			ch0_arm_q <= (ch0_evt || ch0_clr) ? 1'b0 : (ch0_arm_q || (r_ctl0 && ch0_flag_q));
			ch1_arm_q <= (ch1_evt || ch1_clr) ? 1'b0 : (ch1_arm_q || (r_ctl1 && ch1_flag_q));
		end
	end

	// ======================================================
	// Interrupt requests and wake
	assign irq_overflow = ovf_flag_q && ovf_ie_q;
	assign irq_chan0 = ch0_flag_q && ctl0_q[B_IE];
	assign irq_chan1 = ch1_flag_q && ctl1_q[B_IE] && !link;
	assign wake_request = irq_overflow || irq_chan0 || irq_chan1;

	// ======================================================
	// Read data select
	wire [7:0] stat_rd = {ovf_flag_q, ovf_ie_q, halt_q, 2'h0, ps_q};
	wire [7:0] ctl0_rd = {ch0_flag_q, ctl0_q[6:0]};
	wire [7:0] ctl1_rd = {ch1_flag_q, ctl1_q[6:0]};
	logic [31:0] rsel;
	always_comb begin
		case (s_axi_araddr)
			ADDR_STATUS: rsel = {24'h000000, stat_rd};
			ADDR_COUNT: rsel = {16'h0000, cnt_q};
			ADDR_MOD_HI: rsel = {24'h000000, mod_q[15:8]};
			ADDR_MOD_LO: rsel = {24'h000000, mod_q[7:0]};
			ADDR_CH0_CTRL: rsel = {24'h000000, ctl0_rd};
			ADDR_CH0_CMP: rsel = {16'h0000, cmp0_q};
			ADDR_CH1_CTRL: rsel = {24'h000000, ctl1_rd};
			ADDR_CH1_CMP: rsel = {16'h0000, cmp1_q};
			default: rsel = 32'h00000000;
		endcase
	end

	// Responses: one cycle after the request is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OK;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OK;
			rdata_q <= 32'h00000000;
		end else begin
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wait_mode ? RESP_SLVERR :
					(mapped(s_axi_awaddr) ? RESP_OK : RESP_DECERR);
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_ok ? rsel : 32'h00000000;
				rresp_q <= wait_mode ? RESP_SLVERR :
					(mapped(s_axi_araddr) ? RESP_OK : RESP_DECERR);
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ======================================================
	// Checks
	AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
		run && at_mod && !crst |=> cnt_q == 16'h0000) else $error("no wrap");
	AST_INC: assert property (@(posedge aclk) disable iff (!aresetn)
		run && !at_mod && !crst |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
		else $error("no increment");
	AST_HALT: assert property (@(posedge aclk) disable iff (!aresetn)
		(halt_q || stop_mode) && !crst |=> $stable(cnt_q)) else $error("counter moved");
	AST_CRST: assert property (@(posedge aclk) disable iff (!aresetn)
		crst |=> cnt_q == 16'h0000 && !stat_rd[B_CRST]) else $error("reset bit failed");
	AST_OVF: assert property (@(posedge aclk) disable iff (!aresetn)
		ovf_evt |=> ovf_flag_q && irq_overflow == ovf_ie_q) else $error("overflow lost");
	AST_INHIB: assert property (@(posedge aclk) disable iff (!aresetn)
		inhib_q && !ovf_flag_q && !w_mlo |=> !ovf_flag_q) else $error("flag not held off");
	AST_VOID: assert property (@(posedge aclk) disable iff (!aresetn)
		ovf_evt |=> ovf_flag_q && !ovf_arm_q) else $error("clear not voided");
	AST_LINK: assert property (@(posedge aclk) disable iff (!aresetn)
		link |-> !chan1_pin_oe && !irq_chan1) else $error("pin1 not released");
	AST_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_fire && wait_mode |=> rvalid_q && rresp_q == RESP_SLVERR) else $error("wait access");
	CV_WRAP: cover property (@(posedge aclk) disable iff (!aresetn) ovf_evt);
	CV_SWAP: cover property (@(posedge aclk) disable iff (!aresetn) link && cif.wrap && pend_q);
	CV_CLR: cover property (@(posedge aclk) disable iff (!aresetn) ovf_clr);
endmodule : tpcp_top
`default_nettype wire

// File: tpcp_pkg.sv
// Contract
// - Overflow toggles pin when toggle enabled
// - Pulse spans overflow to compare match
// - Modulo 00FF at divide-one gives 256
// - Compare 0080 of 256 gives half duty
// - Unbuffered compare value takes effect immediately
// - Link select bit pairs channels onto pin0
// - Last written compare pair wins at overflow
// - Linked: channel1 control unused, pin released
// - Toggle off gives zero percent duty
// - Max duty with toggle holds full duty
// - Overflow sets flag; irq gated by enable
// - Compare sets channel flag; enabled irq (code sets the flag only when an edge action is selected)
// - Wait: runs, registers blocked, irq wakes
// - Stop: halts, keeps state, resumes after
// - Wrap to zero; high write inhibits flag
// - Flag clears by read then zero write
// - Counter reset self-clears; halt set by reset
// - Prescale codes divide; 111 external clock
package tpcp_pkg;
	// ======================================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_MOD_HI = 8'h08;
	localparam logic [7:0] ADDR_MOD_LO = 8'h0C;
	localparam logic [7:0] ADDR_CH0_CTRL = 8'h10;
	localparam logic [7:0] ADDR_CH0_CMP = 8'h14;
	localparam logic [7:0] ADDR_CH1_CTRL = 8'h18;
	localparam logic [7:0] ADDR_CH1_CMP = 8'h1C;
	// ======================================================
	// Field positions
	localparam int B_FLAG = 7;
	localparam int B_IE = 6;
	localparam int B_HALT = 5;
	localparam int B_CRST = 4;
	localparam int B_LINK = 5;
	localparam int B_MSL = 4;
	localparam int B_ELSH = 3;
	localparam int B_ELSL = 2;
	localparam int B_TOV = 1;
	localparam int B_MAX = 0;
	// ======================================================
	// Reset values and codes
	localparam logic [15:0] MOD_RESET = 16'hFFFF;
	localparam logic [2:0] PS_EXT = 3'h7;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef logic [15:0] tpcp_cnt_t;
endpackage : tpcp_pkg

// File: tpcp_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
// Counter timing shared with channel units
interface tpcp_cnt_if;
	logic tick;
	logic wrap;
	logic [15:0] cnt_nxt;
	modport src (output tick, output wrap, output cnt_nxt);
	modport snk (input tick, input wrap, input cnt_nxt);
endinterface : tpcp_cnt_if
`default_nettype wire

// File: tpcp_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module tpcp_prescale #(
	parameter bit HAS_EXT = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	input wire logic [2:0] sel,
	input wire logic ext_clk,
	output logic tick
);
	import tpcp_pkg::*;
	logic [5:0] div_q;
	logic s1_q, s2_q, s3_q;
	wire [5:0] mask = 6'(({7'h00, 1'b1} << sel) - 8'h01);
	wire ext_edge = HAS_EXT && s2_q && !s3_q;
	// ======================================================
	// Binary divider; code 7 takes synchronised pin edges
	assign tick = (sel == PS_EXT) ? ext_edge : ((div_q & mask) == mask);
	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			div_q <= 6'h00;
		end else begin
			div_q <= div_q + 6'h01;
		end
	end
	// Pin is asynchronous, two stages before the edge detector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= ext_clk;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
endmodule : tpcp_prescale
`default_nettype wire

// File: tpcp_chan.sv
`timescale 1ns/1ps
`default_nettype none
module tpcp_chan (
	input wire logic aclk,
	input wire logic aresetn,
	tpcp_cnt_if.snk cnt,
	input wire logic [15:0] cmp,
	input wire logic [1:0] els,
	input wire logic tov,
	input wire logic max_duty,
	output logic hit,
	output logic pin
);
	import tpcp_pkg::*;
	// Match one tick early so the pin changes as the counter lands
	assign hit = cnt.tick && (cnt.cnt_nxt == cmp);
	wire ovf_pin = (cnt.wrap && tov) ? !pin : pin;
	logic pin_d;
	// ======================================================
	// Compare action applied after the overflow toggle
	always_comb begin
		pin_d = ovf_pin;
		if (max_duty && tov) begin
			pin_d = !els[0];
		end else if (hit) begin
			case (els)
				2'h1: pin_d = !ovf_pin;
				2'h2: pin_d = 1'b0;
				2'h3: pin_d = 1'b1;
				default: pin_d = ovf_pin;
			endcase
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin <= 1'b0;
		end else begin
			pin <= pin_d;
		end
	end
	AST_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		!tov && els[1] && !els[0] && !pin |=> !pin) else $error("zero duty broken");
	AST_MAX: assert property (@(posedge aclk) disable iff (!aresetn)
		max_duty && tov |=> pin == !$past(els[0])) else $error("max duty broken");
	CV_HIT: cover property (@(posedge aclk) disable iff (!aresetn) hit);
endmodule : tpcp_chan
`default_nettype wire

// File: tpcp_load.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Load on a PWM pin: measures period and pulse width in clock cycles
module tpcp_load (
	input wire logic aclk,
	input wire logic pin,
	output int period_cyc,
	output int high_cyc
);
	logic pin_q;
	int cnt;
	// Sampled at the rising edge, like any synchronous receiver would
	initial begin
		pin_q = 1'b0;
		cnt = 0;
		period_cyc = 0;
		high_cyc = 0;
	end
	// Rise to rise is the period, rise to fall the pulse width
	always @(posedge aclk) begin
		pin_q <= pin;
		if (pin === 1'b1 && pin_q === 1'b0) begin
			period_cyc <= cnt;
			cnt <= 1;
		end else begin
			cnt <= cnt + 1;
		end
		if (pin === 1'b0 && pin_q === 1'b1) begin
			high_cyc <= cnt;
		end
	end
endmodule : tpcp_load
`default_nettype wire

// File: test_timer_pwm_channel_pair.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer_pwm_channel_pair;
	import tpcp_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic wait_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic chan0_pin, chan0_pin_oe, chan1_pin, chan1_pin_oe;
	logic irq_overflow, irq_chan0, irq_chan1, wake_request;
	int period_cyc, high_cyc;
	int num_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	// ======================================================
	// Clock 40 MHz and watchdog on the whole run
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			num_errors = num_errors + 1;
			test_done();
		end
	end
	tpcp_top tpcp_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .wait_mode(wait_mode), .stop_mode(stop_mode),
		.external_timer_clock(1'b0), .chan0_pin(chan0_pin),
		.chan0_pin_oe(chan0_pin_oe), .chan1_pin(chan1_pin),
		.chan1_pin_oe(chan1_pin_oe), .irq_overflow(irq_overflow),
		.irq_chan0(irq_chan0), .irq_chan1(irq_chan1), .wake_request(wake_request));
	tpcp_load tpcp_load_inst (.aclk(aclk), .pin(chan0_pin), .period_cyc(period_cyc),
		.high_cyc(high_cyc));
	// ======================================================
	// Bus and compare helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			num_errors = num_errors + 1;
		end
	endtask : chk
	// Address and data are offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : axr
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axw(a, d, r);
		chk({30'h0, r}, {30'h0, RESP_OK});
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(d & m, exp);
		chk({30'h0, r}, {30'h0, RESP_OK});
	endtask : rdc
	// Counts high samples on the channel 0 pin over 512 cycles
	task automatic hi_count(output logic [31:0] n);
		n = 0;
		repeat (512) begin
			@(posedge aclk);
			if (chan0_pin === 1'b1) n = n + 1;
		end
	endtask : hi_count
	// Waits until the channel 0 pin has just changed to the given level
	task automatic pin_edge(input logic v);
		while (chan0_pin !== !v) begin
			@(posedge aclk);
		end
		while (chan0_pin !== v) begin
			@(posedge aclk);
		end
	endtask : pin_edge
	task automatic endt(input string s);
		$display("test %s finished, errors so far %0d", s, num_errors);
	endtask : endt
	// ======================================================
	// Scenarios
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		rdc(ADDR_STATUS, 32'h20, 32'hFF);
		rdc(ADDR_MOD_HI, 32'hFF, 32'hFF);
		axr(8'h40, d, r);
		chk({30'h0, r}, {30'h0, RESP_DECERR});
		chk(d, 32'h0);
		endt("reset");
	endtask : t_reset
	task automatic t_pwm();
		wr(ADDR_STATUS, 32'h30);
		wr(ADDR_MOD_HI, 32'h00);
		wr(ADDR_MOD_LO, 32'hFF);
		wr(ADDR_CH0_CMP, 32'h80);
		wr(ADDR_CH0_CTRL, 32'h5A);
		wr(ADDR_STATUS, 32'h40);
		repeat (800) @(posedge aclk);
		chk(period_cyc, 256);
		chk(high_cyc, 128);
		chk({31'h0, irq_overflow}, 1);
		chk({31'h0, irq_chan0}, 1);
		chk({31'h0, chan0_pin_oe}, 1);
		// Shorten just after the compare, lengthen just after the overflow
		pin_edge(1'b0);
		wr(ADDR_CH0_CMP, 32'h40);
		repeat (600) @(posedge aclk);
		chk(high_cyc, 64);
		pin_edge(1'b1);
		wr(ADDR_CH0_CMP, 32'h80);
		repeat (600) @(posedge aclk);
		chk(high_cyc, 128);
		endt("pwm");
	endtask : t_pwm
	task automatic t_flags();
		wr(ADDR_STATUS, 32'hE0);
		rdc(ADDR_STATUS, 32'hE0, 32'hE0);
		wr(ADDR_STATUS, 32'h20);
		rdc(ADDR_STATUS, 32'h20, 32'hFF);
		chk({31'h0, irq_overflow}, 0);
		rdc(ADDR_CH0_CTRL, 32'hDA, 32'hFF);
		wr(ADDR_CH0_CTRL, 32'h1A);
		rdc(ADDR_CH0_CTRL, 32'h1A, 32'hFF);
		chk({31'h0, irq_chan0}, 0);
		wr(ADDR_MOD_HI, 32'h00);
		wr(ADDR_STATUS, 32'h00);
		repeat (600) @(posedge aclk);
		rdc(ADDR_STATUS, 32'h00, 32'h80);
		wr(ADDR_MOD_LO, 32'hFF);
		repeat (300) @(posedge aclk);
		rdc(ADDR_STATUS, 32'h80, 32'h80);
		endt("flags");
	endtask : t_flags
	task automatic t_duty_ends();
		logic [31:0] n;
		wr(ADDR_CH0_CTRL, 32'h18);
		repeat (300) @(posedge aclk);
		hi_count(n);
		chk(n, 0);
		wr(ADDR_CH0_CTRL, 32'h1B);
		repeat (300) @(posedge aclk);
		hi_count(n);
		chk(n, 512);
		endt("duty_ends");
	endtask : t_duty_ends
	task automatic t_modes();
		logic [31:0] c1, c2;
		logic [1:0] r;
		wr(ADDR_STATUS, 32'h40);
		stop_mode <= 1'b1;
		axr(ADDR_COUNT, c1, r);
		repeat (40) @(posedge aclk);
		axr(ADDR_COUNT, c2, r);
		chk(c2, c1);
		stop_mode <= 1'b0;
		repeat (300) @(posedge aclk);
		axr(ADDR_COUNT, c2, r);
		chk({31'h0, c2 !== c1}, 1);
		wait_mode <= 1'b1;
		axw(ADDR_CH0_CMP, 32'h10, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		axr(ADDR_COUNT, c2, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		chk(c2, 32'h0);
		repeat (300) @(posedge aclk);
		chk({31'h0, wake_request}, 1);
		wait_mode <= 1'b0;
		rdc(ADDR_CH0_CMP, 32'h80, 32'hFFFF);
		endt("modes");
	endtask : t_modes
	task automatic t_prescale();
		wr(ADDR_STATUS, 32'h30);
		wr(ADDR_MOD_HI, 32'h00);
		wr(ADDR_MOD_LO, 32'h0F);
		wr(ADDR_CH0_CMP, 32'h08);
		wr(ADDR_CH0_CTRL, 32'h1A);
		// Every divide code, period 16 ticks, pulse 8 ticks
		for (int c = 0; c < 7; c++) begin
			wr(ADDR_STATUS, c);
			repeat (48 << c) @(posedge aclk);
			chk(period_cyc, 16 << c);
			chk(high_cyc, 8 << c);
		end
		wr(ADDR_STATUS, 32'h30);
		rdc(ADDR_COUNT, 32'h0, 32'hFFFF);
		rdc(ADDR_STATUS, 32'hA0, 32'hFF);
		endt("prescale");
	endtask : t_prescale
	task automatic t_linked();
		wr(ADDR_MOD_LO, 32'hFF);
		wr(ADDR_CH0_CMP, 32'h80);
		wr(ADDR_CH1_CTRL, 32'h5A);
		chk({31'h0, chan1_pin_oe}, 1);
		wr(ADDR_CH0_CTRL, 32'h2A);
		wr(ADDR_STATUS, 32'h00);
		chk({31'h0, chan1_pin_oe}, 0);
		repeat (800) @(posedge aclk);
		chk(high_cyc, 128);
		chk({31'h0, irq_chan1}, 0);
		wr(ADDR_CH1_CMP, 32'h40);
		repeat (600) @(posedge aclk);
		chk(high_cyc, 64);
		wr(ADDR_CH0_CMP, 32'hC0);
		repeat (600) @(posedge aclk);
		chk(high_cyc, 192);
		chk(period_cyc, 256);
		endt("linked");
	endtask : t_linked
	// ======================================================
	// Verdict, reached from the main sequence or the watchdog
	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_pwm();
		t_flags();
		t_duty_ends();
		t_modes();
		t_prescale();
		t_linked();
		test_done();
	end
endmodule : test_timer_pwm_channel_pair
`default_nettype wire
